// ===== design/mcs_clock_control.sv
// How it works
// - Pin carries main clock when enabled and running
// - Monitored main-clock failure clears pin enable
// - Source field picks one of four oscillators
// - External slow source uses kind bit choice
// - External fast source uses kind bit choice
// - Divide field codes map to fixed ratios
// - Prescaler off passes clock, on divides
// - Monitor source field picks the watched clock
// - Full enable with NMI locks fields until reset
// - Writing test one forces a failure while monitor enable is set
// - Writing test zero removes forced failure
// - Monitor enable bit turns detection on
// - Kind bit routes request regular or NMI
// - Interrupt enable gates the failure request
// - Protected writes need key shortly before
// - Failure sets flag, write one clears
// - Main-clock failure reverts to start-up source
`timescale 1ns/10ps
`default_nettype none
module mcs_clock_control
   import mcs_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Clock system
   input  wire logic        mainRunning,
   input  wire logic        slowSourceKind,
   input  wire logic        fastSourceKind,
   input  wire logic [2:0]  oscActivity,
   output logic [3:0]       mainSourceSelect,
   output logic             useSlowExternalClock,
   output logic             useSlowCrystal,
   output logic             useFastExternalClock,
   output logic             useFastCrystal,
   output logic             peripheralClockTick,
   // Clock-out pin
   output logic             mainClockPinOutputEnable,
   // Interrupt requests
   output logic             failureIrq,
   output logic             failureNmi
);

   logic                clockOutOn;
   logic [3:0]          mainSelect;
   logic [3:0]          prescalerDivideSelect;
   logic                prescalerOn;
   logic [1:0]          failureMonitorSource;
   logic                failureMonitorTest;
   logic                failureMonitorOn;
   logic                failureIrqKind;
   logic                failureIrqEnable;
   logic                failureFlag;
   logic                locked;
   logic [2:0]          guardCount;
   logic                runningSync1;
   logic                runningSync2;
   logic                awHeld;
   logic [5:0]          awIndex;
   logic                wHeld;
   logic [7:0]          wByte;
   logic                wLaneOn;
   logic                doWrite;
   logic                guardOpen;
   logic                protWrite;
   logic                mapped;
   logic                failing;
   logic                failEvent;
   logic                mainFail;
   logic                next_locked;
   logic [31:0]         readValue;
   logic                readMapped;
   mcs_monitor_cfg_type monitorCfg;

   function automatic logic isMapped(input logic [5:0] idx);
      isMapped = idx <= IDX_STATUS || idx == IDX_GUARD;
   endfunction : isMapped

   // Write channel: address and data taken in either order
   assign awready = !awHeld && !bvalid;
   assign wready  = !wHeld && !bvalid;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         awHeld  <= 1'b0;
         awIndex <= 6'h00;
      end else if (awvalid && awready) begin
         awHeld  <= 1'b1;
         awIndex <= awaddr[7:2];
      end else if (doWrite) begin
         awHeld  <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wHeld   <= 1'b0;
         wByte   <= 8'h00;
         wLaneOn <= 1'b0;
      end else if (wvalid && wready) begin
         wHeld   <= 1'b1;
         wByte   <= wdata[7:0];
         wLaneOn <= wstrb[0];
      end else if (doWrite) begin
         wHeld   <= 1'b0;
      end
   end

   assign doWrite   = awHeld && wHeld;
   assign mapped    = isMapped(awIndex);
   assign guardOpen = (guardCount != 3'h0);
   assign protWrite = doWrite && wLaneOn && guardOpen;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Key opens a short window; the next protected write closes it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         guardCount <= 3'h0;
      end else if (doWrite && wLaneOn && awIndex == IDX_GUARD && wByte == GUARD_KEY) begin
         guardCount <= 3'(GUARD_WINDOW);
      end else if (protWrite && awIndex <= IDX_IRQ_CTRL) begin
         guardCount <= 3'h0;
      end else if (guardOpen) begin
         guardCount <= guardCount - 3'h1;
      end
   end

   // Main select register
   assign mainFail = failEvent && failureMonitorSource == MON_MAIN;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         clockOutOn <= RST_MAIN_SEL[MAIN_CLOCK_PIN_OUTPUT_BIT];
      end else if (mainFail) begin
         clockOutOn <= 1'b0;
      end else if (protWrite && awIndex == IDX_MAIN_SEL) begin
         clockOutOn <= wByte[MAIN_CLOCK_PIN_OUTPUT_BIT];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mainSelect <= RST_MAIN_SEL[SEL_LSB +: 4];
      end else if (mainFail) begin
         mainSelect <= SRC_INT_FAST;
      end else if (protWrite && awIndex == IDX_MAIN_SEL && wByte[SEL_LSB +: 4] <= SRC_EXT_FAST) begin
         mainSelect <= wByte[SEL_LSB +: 4];
      end
   end

   // Prescaler register; reserved divide codes are not stored
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prescalerOn           <= RST_PRESCALER[PEN_BIT];
         prescalerDivideSelect <= RST_PRESCALER[PRESCALER_DIVIDE_SELECT_LSB +: 4];
      end else if (protWrite && awIndex == IDX_PRESCALER) begin
         prescalerOn <= wByte[PEN_BIT];
         if (wByte[PRESCALER_DIVIDE_SELECT_LSB +: 4] <= 4'h5 ||
             (wByte[PRESCALER_DIVIDE_SELECT_LSB +: 4] >= 4'h8 && wByte[PRESCALER_DIVIDE_SELECT_LSB +: 4] <= 4'hc)) begin
            prescalerDivideSelect <= wByte[PRESCALER_DIVIDE_SELECT_LSB +: 4];
         end
      end
   end

   // Monitor control; locked fields hold, test bit stays writable
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         failureMonitorSource <= RST_MONITOR[MSRC_LSB +: 2];
         failureMonitorOn     <= RST_MONITOR[MON_EN_BIT];
         failureMonitorTest   <= RST_MONITOR[TEST_BIT];
      end else if (protWrite && awIndex == IDX_MONITOR) begin
         failureMonitorTest <= wByte[TEST_BIT];
         if (!locked) begin
            failureMonitorOn <= wByte[MON_EN_BIT];
            if (wByte[MSRC_LSB +: 2] <= MON_EXT_SLOW) begin
               failureMonitorSource <= wByte[MSRC_LSB +: 2];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         failureIrqKind   <= RST_IRQ_CTRL[KIND_BIT];
         failureIrqEnable <= RST_IRQ_CTRL[IRQ_EN_BIT];
      end else if (protWrite && awIndex == IDX_IRQ_CTRL && !locked) begin
         failureIrqKind   <= wByte[KIND_BIT];
         failureIrqEnable <= wByte[IRQ_EN_BIT];
      end
   end

   // Lock holds until reset
   assign next_locked = locked ||
                        (failureMonitorOn && failureIrqEnable && failureIrqKind);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         locked <= 1'b0;
      end else begin
         locked <= next_locked;
      end
   end

   // Flag: a failure in the clearing cycle wins over the clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         failureFlag <= RST_IRQ_FLAGS[FLAG_BIT];
      end else if (failEvent) begin
         failureFlag <= 1'b1;
      end else if (doWrite && wLaneOn && awIndex == IDX_IRQ_FLAGS && wByte[FLAG_BIT]) begin
         failureFlag <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         failureIrq <= 1'b0;
         failureNmi <= 1'b0;
      end else begin
         failureIrq <= failureFlag && failureIrqEnable && !failureIrqKind;
         failureNmi <= failureFlag && failureIrqEnable && failureIrqKind;
      end
   end

   // Source and pin outputs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         runningSync1 <= 1'b0;
         runningSync2 <= 1'b0;
      end else begin
         runningSync1 <= mainRunning;
         runningSync2 <= runningSync1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mainSourceSelect         <= RST_MAIN_SEL[SEL_LSB +: 4];
         useSlowExternalClock     <= 1'b0;
         useSlowCrystal           <= 1'b0;
         useFastExternalClock     <= 1'b0;
         useFastCrystal           <= 1'b0;
         mainClockPinOutputEnable <= 1'b0;
      end else begin
         mainSourceSelect         <= mainSelect;
         useSlowExternalClock     <= mainSelect == SRC_EXT_SLOW && slowSourceKind;
         useSlowCrystal           <= mainSelect == SRC_EXT_SLOW && !slowSourceKind;
         useFastExternalClock     <= mainSelect == SRC_EXT_FAST && fastSourceKind;
         useFastCrystal           <= mainSelect == SRC_EXT_FAST && !fastSourceKind;
         mainClockPinOutputEnable <= clockOutOn && runningSync2;
      end
   end

   assign monitorCfg = '{source: failureMonitorSource,
                         enable: failureMonitorOn,
                         test:   failureMonitorTest};

   mcs_fail_monitor monitor (
      .clock       (clock),
      .nrst        (nrst),
      .cfg         (monitorCfg),
      .oscActivity (oscActivity),
      .failing     (failing),
      .failEvent   (failEvent)
   );

   mcs_prescaler prescaler (
      .clock        (clock),
      .nrst         (nrst),
      .prescalerOn  (prescalerOn),
      .divideSelect (prescalerDivideSelect),
      .periphTick   (peripheralClockTick)
   );

   // Read channel
   assign arready    = !rvalid;
   assign readMapped = isMapped(araddr[7:2]);

   always_comb begin
      readValue = 32'h0000_0000;
      unique case (araddr[7:2])
         IDX_MAIN_SEL:  readValue[7:0] = {clockOutOn, 3'h0, mainSelect};
         IDX_PRESCALER: readValue[7:0] = {3'h0, prescalerDivideSelect, prescalerOn};
         IDX_MONITOR:   readValue[7:0] = {4'h0, failureMonitorSource,
                                          failureMonitorTest, failureMonitorOn};
         IDX_IRQ_CTRL:  readValue[7:0] = {failureIrqKind, 6'h00, failureIrqEnable};
         IDX_IRQ_FLAGS: readValue[7:0] = {7'h00, failureFlag};
         IDX_STATUS:    readValue[7:0] = {5'h00, mainClockPinOutputEnable, locked, failing};
         default:       readValue = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= readValue;
         rresp  <= readMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule : mcs_clock_control
`default_nettype wire

// ===== design/mcs_fail_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mcs_fail_monitor
   import mcs_pkg::*;
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                nrst,
   // Setting
   input  wire mcs_monitor_cfg_type cfg,
   // Activity toggles: main, external fast, external slow
   input  wire logic [2:0]          oscActivity,
   // Result
   output logic                     failing,
   output logic                     failEvent
);

   logic [2:0]  syncA;
   logic [2:0]  syncB;
   logic [2:0]  syncC;
   logic [2:0]  seen;
   logic [11:0] idle;
   logic        timedOut;
   logic        condition;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         syncA <= 3'h0;
         syncB <= 3'h0;
         syncC <= 3'h0;
      end else begin
         syncA <= oscActivity;
         syncB <= syncA;
         syncC <= syncB;
      end
   end

   assign seen = syncB ^ syncC;

   // Idle time of the monitored source
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         idle <= 12'h000;
      end else if (!cfg.enable || seen[cfg.source] || cfg.source == 2'h3) begin
         idle <= 12'h000;
      end else if (!timedOut) begin
         idle <= idle + 12'h001;
      end
   end

   assign timedOut  = (idle >= 12'(FAIL_TIMEOUT_CYC));
   assign condition = cfg.enable && (timedOut || cfg.test);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         failing   <= 1'b0;
         failEvent <= 1'b0;
      end else begin
         failing   <= condition;
         failEvent <= condition && !failing;
      end
   end

endmodule : mcs_fail_monitor
`default_nettype wire

// ===== design/mcs_pkg.sv
`default_nettype none
package mcs_pkg;

   // Clock and timing
   localparam int unsigned CLOCK_HZ         = 25_000_000;
   localparam int unsigned FAIL_TIMEOUT_NS  = 100_000;
   localparam int unsigned FAIL_TIMEOUT_CYC =
      (FAIL_TIMEOUT_NS * (CLOCK_HZ / 1_000_000)) / 1000;
   localparam int unsigned GUARD_WINDOW     = 4;

   // Register indices (byte address is four times the index)
   localparam logic [5:0] IDX_MAIN_SEL   = 6'h00;
   localparam logic [5:0] IDX_PRESCALER  = 6'h01;
   localparam logic [5:0] IDX_MONITOR    = 6'h02;
   localparam logic [5:0] IDX_IRQ_CTRL   = 6'h03;
   localparam logic [5:0] IDX_IRQ_FLAGS  = 6'h04;
   localparam logic [5:0] IDX_STATUS     = 6'h05;
   localparam logic [5:0] IDX_GUARD      = 6'h08;

   // Field positions
   localparam int unsigned MAIN_CLOCK_PIN_OUTPUT_BIT  = 7;
   localparam int unsigned SEL_LSB     = 0;
   localparam int unsigned PRESCALER_DIVIDE_SELECT_LSB    = 1;
   localparam int unsigned PEN_BIT     = 0;
   localparam int unsigned MSRC_LSB    = 2;
   localparam int unsigned TEST_BIT    = 1;
   localparam int unsigned MON_EN_BIT  = 0;
   localparam int unsigned KIND_BIT    = 7;
   localparam int unsigned IRQ_EN_BIT  = 0;
   localparam int unsigned FLAG_BIT    = 0;
   localparam int unsigned ST_FAIL_BIT = 0;
   localparam int unsigned ST_LOCK_BIT = 1;
   localparam int unsigned ST_PIN_BIT  = 2;

   // Reset values
   localparam logic [7:0] RST_MAIN_SEL  = 8'h00;
   localparam logic [7:0] RST_PRESCALER = 8'h11;
   localparam logic [7:0] RST_MONITOR   = 8'h00;
   localparam logic [7:0] RST_IRQ_CTRL  = 8'h00;
   localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;

   // Main source codes
   localparam logic [3:0] SRC_INT_FAST = 4'h0;
   localparam logic [3:0] SRC_INT_SLOW = 4'h1;
   localparam logic [3:0] SRC_EXT_SLOW = 4'h2;
   localparam logic [3:0] SRC_EXT_FAST = 4'h3;

   // Monitored source codes
   localparam logic [1:0] MON_MAIN     = 2'h0;
   localparam logic [1:0] MON_EXT_FAST = 2'h1;
   localparam logic [1:0] MON_EXT_SLOW = 2'h2;

   // Unlock key, arbitrary value
   localparam logic [7:0] GUARD_KEY = 8'ha5;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] source;
      logic       enable;
      logic       test;
   } mcs_monitor_cfg_type;

endpackage : mcs_pkg
`default_nettype wire

// ===== design/mcs_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module mcs_prescaler
   import mcs_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // Setting
   input  wire logic       prescalerOn,
   input  wire logic [3:0] divideSelect,
   // Peripheral clock enable
   output logic            periphTick
);

   function automatic logic [6:0] ratioOf(input logic [3:0] code);
      unique case (code)
         4'h0:    ratioOf = 7'd2;
         4'h1:    ratioOf = 7'd4;
         4'h2:    ratioOf = 7'd8;
         4'h3:    ratioOf = 7'd16;
         4'h4:    ratioOf = 7'd32;
         4'h5:    ratioOf = 7'd64;
         4'h8:    ratioOf = 7'd6;
         4'h9:    ratioOf = 7'd10;
         4'ha:    ratioOf = 7'd12;
         4'hb:    ratioOf = 7'd24;
         default: ratioOf = 7'd48;
      endcase
   endfunction : ratioOf

   logic [6:0] count;
   logic       wrap;

   assign wrap = (count >= ratioOf(divideSelect) - 7'd1);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count <= 7'd0;
      end else if (!prescalerOn || wrap) begin
         count <= 7'd0;
      end else begin
         count <= count + 7'd1;
      end
   end

   // Undivided when off, one tick per ratio when on
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         periphTick <= 1'b0;
      end else begin
         periphTick <= !prescalerOn || wrap;
      end
   end

endmodule : mcs_prescaler
`default_nettype wire

// ===== test/mcs_clock_control_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mcs_clock_control_chk
   import mcs_pkg::*;
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       nrst,
   // Register bus
   input wire logic       awready,
   input wire logic       wready,
   input wire logic       bvalid,
   input wire logic [1:0] bresp,
   input wire logic       arvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   // Clock system
   input wire logic       mainRunning,
   input wire logic       slowSourceKind,
   input wire logic       fastSourceKind,
   input wire logic [3:0] mainSourceSelect,
   input wire logic       useSlowExternalClock,
   input wire logic       useSlowCrystal,
   input wire logic       useFastExternalClock,
   input wire logic       useFastCrystal,
   input wire logic       mainClockPinOutputEnable,
   input wire logic       failureIrq,
   input wire logic       failureNmi
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_SRC_LEGAL: assert property (mainSourceSelect <= SRC_EXT_FAST)
      else $error("main source code out of range");
   AST_SLOW_EXT: assert property ((mainSourceSelect == SRC_EXT_SLOW && slowSourceKind)[*3]
      |-> useSlowExternalClock && !useSlowCrystal) else $error("slow source kind ignored");
   AST_FAST_XTAL: assert property ((mainSourceSelect == SRC_EXT_FAST && !fastSourceKind)[*3]
      |-> useFastCrystal && !useFastExternalClock) else $error("fast source kind ignored");
   AST_PIN_STOP: assert property ((!mainRunning)[*4] |-> !mainClockPinOutputEnable)
      else $error("pin driven while main clock stopped");
   AST_IRQ_ROUTE: assert property (!(failureIrq && failureNmi))
      else $error("request on both outputs");
   AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read not answered next cycle");
   AST_WR_BLOCK: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   AST_BRESP: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
      else $error("illegal write response");
endmodule : mcs_clock_control_chk

bind mcs_clock_control mcs_clock_control_chk mcs_clock_control_chk_i (
   .clock, .nrst, .awready, .wready, .bvalid, .bresp, .arvalid, .arready, .rvalid,
   .mainRunning, .slowSourceKind, .fastSourceKind, .mainSourceSelect,
   .useSlowExternalClock, .useSlowCrystal, .useFastExternalClock, .useFastCrystal,
   .mainClockPinOutputEnable, .failureIrq, .failureNmi
);
`default_nettype wire

// ===== test/tb_mcs_clock_control.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, m, g, e); \
   end \
end
module tb_mcs_clock_control import mcs_pkg::*;;
   logic        clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, mainRunning, slowSourceKind;
   logic        fastSourceKind, useSlowExternalClock, useSlowCrystal, failureIrq;
   logic        useFastExternalClock, useFastCrystal, peripheralClockTick, failureNmi;
   logic        mainClockPinOutputEnable;
   logic [1:0]  bresp, rresp, resp;
   logic [2:0]  oscActivity = 3'h0, oscAlive;
   logic [3:0]  wstrb, mainSourceSelect, code, divNow, srcNow;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rdw;
   int          n_mismatch, n_compared, gap;
   int          divTbl[16] = '{2, 4, 8, 16, 32, 64, 0, 0, 6, 10, 12, 24, 48, 0, 0, 0};

   mcs_clock_control mcs_clock_control_i (
      .clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .mainRunning, .slowSourceKind, .fastSourceKind, .oscActivity,
      .mainSourceSelect, .useSlowExternalClock, .useSlowCrystal, .useFastExternalClock,
      .useFastCrystal, .peripheralClockTick, .mainClockPinOutputEnable, .failureIrq,
      .failureNmi
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Oscillators that are alive keep toggling their activity line
   always @(posedge clock) oscActivity <= oscActivity ^ oscAlive;

   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic give_up;
      n_mismatch++;
      $display("CHECK FAILED at %0t: bus hang", $time);
      tally_and_finish();
   endtask : give_up

   task automatic reset_pulse;
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
   endtask : reset_pulse

   task automatic bus_write(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
      int   n;
      logic aOk, wOk;
      n = 0;
      aOk = 1'b0;
      wOk = 1'b0;
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (!aOk && awready) begin
            aOk = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wOk && wready) begin
            wOk = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!bvalid && n < 50);
      resp = bresp;
      if (!bvalid) give_up();
   endtask : bus_write

   task automatic bus_read(input logic [5:0] idx);
      int   n;
      logic aOk;
      n = 0;
      aOk = 1'b0;
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (!aOk && arready) begin
            aOk = 1'b1;
            arvalid <= 1'b0;
         end
      end while (!rvalid && n < 50);
      rdw = rdata;
      resp = rresp;
      if (!rvalid) give_up();
   endtask : bus_read

   task automatic expect_reg(input logic [5:0] idx, input logic [7:0] e);
      bus_read(idx);
      `CHK(rdw, {24'h0, e}, "register")
   endtask : expect_reg

   task automatic guarded_write(input logic [5:0] idx, input logic [7:0] d);
      bus_write(IDX_GUARD, GUARD_KEY, 4'hf);
      bus_write(idx, d, 4'hf);
   endtask : guarded_write

   task automatic poll_flag(input logic e, input int bound);
      int n;
      n = 0;
      do begin
         bus_read(IDX_IRQ_FLAGS);
         n++;
      end while (rdw[0] !== e && n < bound);
      `CHK(rdw[0], e, "flag")
   endtask : poll_flag

   // Distance between two ticks, after letting the divider settle
   task automatic tick_gap;
      for (int k = 0; k < 3; k++) begin
         gap = 0;
         do begin
            @(posedge clock);
            gap++;
         end while (!peripheralClockTick && gap < 200);
      end
   endtask : tick_gap

   initial begin
      n_mismatch = 0;
      n_compared = 0;
      {awvalid, wvalid, arvalid, bready, rready} = 5'h03;
      {awaddr, araddr, wdata, wstrb} = '0;
      {mainRunning, slowSourceKind, fastSourceKind} = 3'h1;
      oscAlive = 3'h7;
      void'($urandom(11938));
      reset_pulse();
      for (int i = 0; i < 5; i++) expect_reg(6'(i), (i == 1) ? 8'h11 : 8'h00);
      bus_read(6'h06);
      `CHK({resp, rdw}, {RESP_SLVERR, 32'h0}, "unmapped read")
      bus_write(6'h07, 8'hff, 4'hf);
      `CHK(resp, RESP_SLVERR, "unmapped write")
      bus_write(IDX_MAIN_SEL, 8'h83, 4'hf);
      bus_write(IDX_GUARD, GUARD_KEY, 4'hf);
      bus_write(IDX_MAIN_SEL, 8'h83, 4'h0);
      expect_reg(IDX_MAIN_SEL, 8'h00);
      $display("test map and guard done");
      srcNow = 4'h0;
      for (int k = 0; k < 7; k++) begin
         code = (k < 5) ? 4'(k) : 4'($urandom_range(15));
         slowSourceKind <= 1'($urandom);
         fastSourceKind <= 1'($urandom);
         guarded_write(IDX_MAIN_SEL, {4'h0, code});
         if (code <= SRC_EXT_FAST) srcNow = code;
         repeat (3) @(posedge clock);
         `CHK(mainSourceSelect, srcNow, "source")
         if (srcNow == SRC_EXT_SLOW)
            `CHK(useSlowCrystal, !slowSourceKind, "slow kind")
         if (srcNow == SRC_EXT_FAST)
            `CHK(useFastExternalClock, fastSourceKind, "fast kind")
      end
      guarded_write(IDX_MAIN_SEL, 8'h83);
      mainRunning <= 1'b0;
      repeat (5) @(posedge clock);
      `CHK(mainClockPinOutputEnable, 1'b0, "pin stopped")
      mainRunning <= 1'b1;
      repeat (5) @(posedge clock);
      `CHK(mainClockPinOutputEnable, 1'b1, "pin on")
      $display("test sources done");
      divNow = 4'h8;
      for (int k = 0; k < 20; k++) begin
         code = (k < 16) ? 4'(k) : 4'($urandom_range(15));
         guarded_write(IDX_PRESCALER, {3'h0, code, 1'b1});
         if (divTbl[code] != 0) divNow = code;
         tick_gap();
         `CHK(gap, divTbl[divNow], "tick gap")
      end
      guarded_write(IDX_PRESCALER, 8'h10);
      tick_gap();
      `CHK(gap, 1, "undivided")
      $display("test prescaler done");
      guarded_write(IDX_IRQ_CTRL, 8'h01);
      guarded_write(IDX_MONITOR, 8'h02);
      repeat (20) @(posedge clock);
      expect_reg(IDX_IRQ_FLAGS, 8'h00);
      guarded_write(IDX_MONITOR, 8'h03);
      poll_flag(1'b1, 10);
      `CHK({failureIrq, failureNmi}, 2'b10, "regular request")
      `CHK(mainClockPinOutputEnable, 1'b0, "pin after failure")
      expect_reg(IDX_MAIN_SEL, 8'h00);
      guarded_write(IDX_MONITOR, 8'h01);
      bus_write(IDX_IRQ_FLAGS, 8'h00, 4'hf);
      poll_flag(1'b1, 1);
      bus_write(IDX_IRQ_FLAGS, 8'h01, 4'hf);
      poll_flag(1'b0, 1);
      expect_reg(IDX_STATUS, 8'h00);
      `CHK(failureIrq, 1'b0, "request gone")
      guarded_write(IDX_IRQ_CTRL, 8'h00);
      guarded_write(IDX_MAIN_SEL, 8'h83);
      guarded_write(IDX_MONITOR, 8'h07);
      poll_flag(1'b1, 10);
      `CHK(failureIrq, 1'b0, "masked")
      expect_reg(IDX_MAIN_SEL, 8'h83);
      guarded_write(IDX_MONITOR, 8'h05);
      bus_write(IDX_IRQ_FLAGS, 8'h01, 4'hf);
      oscAlive <= 3'h5;
      poll_flag(1'b1, 1500);
      oscAlive <= 3'h7;
      guarded_write(IDX_MONITOR, 8'h00);
      bus_write(IDX_IRQ_FLAGS, 8'h01, 4'hf);
      $display("test failure done");
      guarded_write(IDX_IRQ_CTRL, 8'h81);
      guarded_write(IDX_MONITOR, 8'h09);
      guarded_write(IDX_MONITOR, 8'h00);
      guarded_write(IDX_IRQ_CTRL, 8'h00);
      expect_reg(IDX_MONITOR, 8'h09);
      expect_reg(IDX_IRQ_CTRL, 8'h81);
      guarded_write(IDX_MONITOR, 8'h0b);
      poll_flag(1'b1, 10);
      `CHK({failureIrq, failureNmi}, 2'b01, "nmi request")
      expect_reg(IDX_STATUS, 8'h07);
      reset_pulse();
      expect_reg(IDX_IRQ_CTRL, 8'h00);
      $display("test lock done");
      tally_and_finish();
   end
endmodule : tb_mcs_clock_control
`default_nettype wire
